/* hw/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;
   // Register indices on the plain register port
   localparam logic [2:0] IDX_CTRL_A = 3'h0;
   localparam logic [2:0] IDX_CTRL_B = 3'h1;
   localparam logic [2:0] IDX_RES_HI = 3'h2;
   localparam logic [2:0] IDX_RES_LO = 3'h3;
   localparam logic [2:0] IDX_IRQ_STS = 3'h4;
   localparam logic [2:0] IDX_IRQ_MASK = 3'h5;
   localparam logic [2:0] IDX_PIN_SEL = 3'h6;

   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int RES_W = 12;
   localparam int CHAN_N = 4;
   localparam int DIV_W = 3;
   localparam int CONV_CLKS_DEF = 16;
   localparam int CLK_PERIOD_NS = 100;

   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [3:0] ZERO_NIB = 4'h0;
   localparam logic [3:0] ZERO_PINS = 4'h0;

   // Source select encodings
   localparam logic [2:0] SRC_EXT = 3'h0;
   localparam logic [2:0] SRC_BANDGAP = 3'h1;
   localparam logic [2:0] SRC_AMP0 = 3'h2;
   localparam logic [2:0] SRC_AMP1 = 3'h3;
   localparam logic [2:0] SRC_RSVD = 3'h4;

   typedef struct packed {
      logic start;
      logic busy;
      logic enable;
      logic fmt;
      logic [3:0] chan;
   } ctrl_a_t;

   typedef struct packed {
      logic [2:0] src;
      logic [1:0] vref;
      logic [2:0] ckdiv;
   } ctrl_b_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // Route for the single converter input
   typedef struct packed {
      logic bandgap;
      logic amp0;
      logic amp1;
      logic [CHAN_N-1:0] ext;
   } mux_sel_t;

   typedef struct packed {
      logic [CHAN_N-1:0] analog;
      logic [CHAN_N-1:0] io_off;
      logic [CHAN_N-1:0] pullup_off;
   } pin_ctl_t;
endpackage

/* hw/adc_clk_div.sv */
`timescale 1ns/100ps
`default_nettype none
module adc_clk_div #(
   parameter int SEL_W = 3
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire logic run_i,
   input wire logic [SEL_W-1:0] sel_i,
   output logic tick_o
);
   import adc_ctrl_pkg::*;

   localparam int CNT_W = (1 << SEL_W) - 1;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic tick;
   } div_state_t;

   div_state_t st, next_st;
   logic [CNT_W-1:0] limit;

   // One tick every 2**sel system clocks; restarts when idle
   always_comb begin
      next_st = st;
      limit = CNT_W'((1 << sel_i) - 1);
      next_st.tick = 1'b0;
      if (!run_i) begin
         next_st.cnt = '0;
      end else if (st.cnt >= limit) begin
         next_st.cnt = '0;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st <= '0;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign tick_o = st.tick;
endmodule
`default_nettype wire

/* hw/adc_control.sv */
// How it works
// - A start bit written high then low, with enable set, launches exactly one conversion.
// - Busy flag rises once a conversion is launched.
// - Busy flag falls when the conversion completes.
// - Busy is bit six of control A and ignores writes.
// - Enable bit five powers the converter; low switches it off.
// - With the converter off, both result bytes keep their contents.
// - Format zero: high byte D11..D4; format one: high D11..D8, low D7..D0.
// - Channel codes 0..3 route inputs zero to three; others route none.
// - Source select in control B picks internal node or external channel.
// - Only one source drives the converter input at any time.
// - A pin chosen as analog input loses its I/O function.
// - A pin chosen as analog input loses its pull-up.
// - Both control registers are eight bits; control A resets to zero.
// - Unused result bit positions read as zero.
// - Source codes: 0 ext, 1 bandgap, 2 amp0, 3 amp1, 4 none, 5-7 ext.
// - Completion sets the interrupt flag, raising the interrupt if enabled.
// - Converter clock is system clock divided by two to the code.
`timescale 1ns/100ps
`default_nettype none
module adc_control #(
   parameter int CONV_CLKS = adc_ctrl_pkg::CONV_CLKS_DEF
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ce_i,
   input wire adc_ctrl_pkg::reg_req_t req_i,
   input wire logic [adc_ctrl_pkg::RES_W-1:0] adc_result_i,
   output logic [adc_ctrl_pkg::DATA_W-1:0] rdata_o,
   output logic irq_o,
   output logic conv_power_o,
   output logic conv_busy_flag_o,
   output logic conv_clk_tick_o,
   output logic sample_o,
   output logic [1:0] vref_sel_o,
   output var adc_ctrl_pkg::mux_sel_t mux_o,
   output var adc_ctrl_pkg::pin_ctl_t pins_o
);
   import adc_ctrl_pkg::*;

   localparam int TICK_W = $clog2(CONV_CLKS + 1);

   typedef enum logic [1:0] {
      IDLE,
      SAMPLE,
      CONVERT
   } conv_state_t;

   typedef struct packed {
      ctrl_a_t conv_ctrl_reg_a;
      ctrl_b_t conv_ctrl_reg_b;
      logic [7:0] result_high_byte;
      logic [7:0] result_low_byte;
      logic [7:0] rdata;
      logic done_sts;
      logic done_mask;
      logic irq;
      logic [CHAN_N-1:0] pin_sel;
      conv_state_t fsm;
      logic [TICK_W-1:0] ticks;
      logic sample;
      logic clk_tick;
      mux_sel_t mux;
      pin_ctl_t pins;
   } ctl_state_t;

   ctl_state_t st, next_st;
   logic div_tick;

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers
   ////////////////////////////////////////////////////////////////////////////

   function automatic logic is_ext_source(input logic [2:0] src);
      is_ext_source = (src == SRC_EXT) || (src > SRC_RSVD);
   endfunction

   function automatic logic is_access(input reg_req_t r, input logic [2:0] idx, input logic wr);
      is_access = (r.addr == idx) && (wr ? r.wr : r.rd);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Converter clock divider
   ////////////////////////////////////////////////////////////////////////////

   adc_clk_div #(
      .SEL_W(DIV_W)
   ) i_adc_clk_div (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .run_i(st.conv_ctrl_reg_a.enable),
      .sel_i(st.conv_ctrl_reg_b.ckdiv),
      .tick_o(div_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   ////////////////////////////////////////////////////////////////////////////

   always_comb begin
      ctrl_a_t wa;
      logic launch;
      logic done;
      next_st = st;
      wa = ctrl_a_t'(req_i.wdata);
      launch = 1'b0;
      done = 1'b0;
      next_st.clk_tick = div_tick;
      next_st.sample = 1'b0;

      // Register writes
      if (is_access(req_i, IDX_CTRL_A, 1'b1)) begin
         // Falling start edge after a stored high, with enable set, starts a conversion
         launch = st.conv_ctrl_reg_a.start && !wa.start && wa.enable;
         next_st.conv_ctrl_reg_a.start = wa.start;
         next_st.conv_ctrl_reg_a.enable = wa.enable;
         next_st.conv_ctrl_reg_a.fmt = wa.fmt;
         next_st.conv_ctrl_reg_a.chan = wa.chan;
         // Busy position is not writable
      end else if (is_access(req_i, IDX_CTRL_B, 1'b1)) begin
         next_st.conv_ctrl_reg_b = ctrl_b_t'(req_i.wdata);
      end else if (is_access(req_i, IDX_IRQ_MASK, 1'b1)) begin
         next_st.done_mask = req_i.wdata[0];
      end else if (is_access(req_i, IDX_PIN_SEL, 1'b1)) begin
         next_st.pin_sel = req_i.wdata[CHAN_N-1:0];
      end

      // Conversion sequencer; a restart during a conversion is ignored
      case (st.fsm)
         IDLE: begin
            if (launch) begin
               next_st.fsm = SAMPLE;
               next_st.conv_ctrl_reg_a.busy = 1'b1;
               next_st.ticks = '0;
            end
         end
         SAMPLE: begin
            next_st.sample = 1'b1;
            if (div_tick) begin
               next_st.fsm = CONVERT;
               next_st.ticks = TICK_W'(1);
            end
         end
         CONVERT: begin
            if (div_tick) begin
               if (st.ticks >= TICK_W'(CONV_CLKS)) begin
                  done = 1'b1;
               end else begin
                  next_st.ticks = st.ticks + TICK_W'(1);
               end
            end
         end
         default: begin
            next_st.fsm = IDLE;
         end
      endcase

      // Switching off aborts and leaves the result bytes alone
      if (!next_st.conv_ctrl_reg_a.enable) begin
         next_st.fsm = IDLE;
         next_st.conv_ctrl_reg_a.busy = 1'b0;
         next_st.sample = 1'b0;
         done = 1'b0;
      end

      if (done) begin
         // Result lands in the same cycle that busy drops
         next_st.fsm = IDLE;
         next_st.conv_ctrl_reg_a.busy = 1'b0;
         if (st.conv_ctrl_reg_a.fmt) begin
            next_st.result_high_byte = {ZERO_NIB, adc_result_i[11:8]};
            next_st.result_low_byte = adc_result_i[7:0];
         end else begin
            next_st.result_high_byte = adc_result_i[11:4];
            next_st.result_low_byte = {adc_result_i[3:0], ZERO_NIB};
         end
      end

      // Read data, one cycle after the strobe
      next_st.rdata = ZERO_BYTE;
      if (req_i.rd) begin
         if (req_i.addr == IDX_CTRL_A) begin
            next_st.rdata = st.conv_ctrl_reg_a;
         end else if (req_i.addr == IDX_CTRL_B) begin
            next_st.rdata = st.conv_ctrl_reg_b;
         end else if (req_i.addr == IDX_RES_HI) begin
            next_st.rdata = st.result_high_byte;
         end else if (req_i.addr == IDX_RES_LO) begin
            next_st.rdata = st.result_low_byte;
         end else if (req_i.addr == IDX_IRQ_STS) begin
            next_st.rdata = {7'h00, st.done_sts};
         end else if (req_i.addr == IDX_IRQ_MASK) begin
            next_st.rdata = {7'h00, st.done_mask};
         end else if (req_i.addr == IDX_PIN_SEL) begin
            next_st.rdata = {ZERO_NIB, st.pin_sel};
         end
      end

      // Read of status clears; a completion in the same cycle wins
      if (is_access(req_i, IDX_IRQ_STS, 1'b0)) begin
         next_st.done_sts = 1'b0;
      end
      if (done) begin
         next_st.done_sts = 1'b1;
      end
      next_st.irq = next_st.done_sts && next_st.done_mask;

      // Single converter input: internal node or one external channel
      next_st.mux = '0;
      if (is_ext_source(next_st.conv_ctrl_reg_b.src)) begin
         for (int i = 0; i < CHAN_N; i++) begin
            next_st.mux.ext[i] = (next_st.conv_ctrl_reg_a.chan == 4'(i));
         end
      end else if (next_st.conv_ctrl_reg_b.src == SRC_BANDGAP) begin
         next_st.mux.bandgap = 1'b1;
      end else if (next_st.conv_ctrl_reg_b.src == SRC_AMP0) begin
         next_st.mux.amp0 = 1'b1;
      end else if (next_st.conv_ctrl_reg_b.src == SRC_AMP1) begin
         next_st.mux.amp1 = 1'b1;
      end

      // Analog pins drop their digital function and pull-up
      next_st.pins.analog = next_st.pin_sel;
      next_st.pins.io_off = next_st.pin_sel;
      next_st.pins.pullup_off = next_st.pin_sel;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   ////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st <= '0;
         st.conv_ctrl_reg_a <= ctrl_a_t'(CTRL_RESET);
         st.conv_ctrl_reg_b <= ctrl_b_t'(CTRL_RESET);
         st.fsm <= IDLE;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign rdata_o = st.rdata;
   assign irq_o = st.irq;
   assign conv_power_o = st.conv_ctrl_reg_a.enable;
   assign conv_busy_flag_o = st.conv_ctrl_reg_a.busy;
   assign conv_clk_tick_o = st.clk_tick;
   assign sample_o = st.sample;
   assign vref_sel_o = st.conv_ctrl_reg_b.vref;
   assign mux_o = st.mux;
   assign pins_o = st.pins;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   ////////////////////////////////////////////////////////////////////////////

   logic start_seen;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         start_seen <= 1'b0;
      end else if (ce_i) begin
         start_seen <= st.conv_ctrl_reg_a.start;
      end
   end

   sequence s_start_fall;
      ce_i && req_i.wr && req_i.addr == IDX_CTRL_A && st.conv_ctrl_reg_a.start
         && !req_i.wdata[7] && req_i.wdata[5] && st.fsm == IDLE;
   endsequence

   sequence s_busy_fall;
      $fell(st.conv_ctrl_reg_a.busy);
   endsequence

   property p_launch;
      @(posedge clk_i) disable iff (!rstn_i)
      s_start_fall |=> st.conv_ctrl_reg_a.busy && st.fsm == SAMPLE;
   endproperty
   a_launch: assert property (p_launch) else $error("start pulse did not launch");

   property p_busy_only_on_start;
      @(posedge clk_i) disable iff (!rstn_i)
      $rose(conv_busy_flag_o) |-> $past(req_i.wr) && $past(req_i.addr) == IDX_CTRL_A
         && start_seen && !$past(req_i.wdata[7]);
   endproperty
   a_busy_only_on_start: assert property (p_busy_only_on_start)
      else $error("busy rose without start write");

   property p_busy_clears;
      @(posedge clk_i) disable iff (!rstn_i)
      st.fsm == CONVERT && div_tick && ce_i && conv_power_o
         && st.ticks >= TICK_W'(CONV_CLKS) |=> !conv_busy_flag_o && st.fsm == IDLE;
   endproperty
   a_busy_clears: assert property (p_busy_clears) else $error("busy stuck after finish");

   property p_busy_ro;
      @(posedge clk_i) disable iff (!rstn_i)
      ce_i && req_i.wr && req_i.addr == IDX_CTRL_A && st.fsm == IDLE
         |=> conv_busy_flag_o == ($past(st.conv_ctrl_reg_a.start) && !$past(req_i.wdata[7])
            && $past(req_i.wdata[5]));
   endproperty
   a_busy_ro: assert property (p_busy_ro) else $error("busy written by software");

   property p_off_idle;
      @(posedge clk_i) disable iff (!rstn_i)
      !conv_power_o |-> !conv_busy_flag_o && !sample_o;
   endproperty
   a_off_idle: assert property (p_off_idle) else $error("converter active while off");

   property p_hold_off;
      @(posedge clk_i) disable iff (!rstn_i)
      !conv_power_o ##1 !conv_power_o |-> $stable(st.result_high_byte)
         && $stable(st.result_low_byte);
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("result changed while off");

   property p_format;
      @(posedge clk_i) disable iff (!rstn_i)
      s_busy_fall ##0 conv_power_o |->
         ($past(st.conv_ctrl_reg_a.fmt) ? st.result_low_byte == $past(adc_result_i[7:0])
            : st.result_high_byte == $past(adc_result_i[11:4]));
   endproperty
   a_format: assert property (p_format) else $error("result justified wrongly");

   property p_unused_zero;
      @(posedge clk_i) disable iff (!rstn_i)
      s_busy_fall ##0 conv_power_o |->
         ($past(st.conv_ctrl_reg_a.fmt) ? st.result_high_byte[7:4] == ZERO_NIB
            : st.result_low_byte[3:0] == ZERO_NIB);
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused result bits set");

   property p_one_source;
      @(posedge clk_i) disable iff (!rstn_i)
      $countones({mux_o.bandgap, mux_o.amp0, mux_o.amp1, mux_o.ext}) <= 1;
   endproperty
   a_one_source: assert property (p_one_source) else $error("two sources on converter");

   property p_irq_on_done;
      @(posedge clk_i) disable iff (!rstn_i)
      s_busy_fall ##0 conv_power_o |-> st.done_sts ##1 (irq_o == st.done_mask
         || !st.done_sts);
   endproperty
   a_irq_on_done: assert property (p_irq_on_done) else $error("completion flag missing");

   property p_pullup_off;
      @(posedge clk_i) disable iff (!rstn_i)
      pins_o.analog == pins_o.pullup_off && pins_o.analog == pins_o.io_off;
   endproperty
   a_pullup_off: assert property (p_pullup_off) else $error("analog pin kept digital");

   property p_ctrl_reset;
      @(posedge clk_i)
      !rstn_i |=> rstn_i || (st.conv_ctrl_reg_a == ctrl_a_t'(CTRL_RESET));
   endproperty
   a_ctrl_reset: assert property (p_ctrl_reset) else $error("control A not reset");
endmodule
`default_nettype wire

/* verification/analog_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
module analog_core_model (
   input wire logic clk_i,
   input wire logic busy_i,
   input wire adc_ctrl_pkg::mux_sel_t mux_i,
   output logic [adc_ctrl_pkg::RES_W-1:0] result_o
);
   import adc_ctrl_pkg::*;
   logic [RES_W-1:0] level;
   ////////////////////////////////////////////////////////////////////////////////
   // Fixed level per routed source; nothing routed reads full scale
   always_comb begin
      level = 12'hFFF;
      if (mux_i.bandgap) level = 12'h5A3;
      if (mux_i.amp0) level = 12'hC3C;
      if (mux_i.amp1) level = 12'h19E;
      for (int i = 0; i < CHAN_N; i++) begin
         if (mux_i.ext[i]) level = 12'hA50 | 12'(i);
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Outside a conversion the output toggles so a stale sample cannot pass
   initial result_o = 12'h000;
   always @(posedge clk_i) begin
      if (busy_i) result_o <= level;
      else result_o <= ~result_o;
   end
endmodule
`default_nettype wire

/* verification/tb_adc_control_channel_select.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_adc_control_channel_select;
   import adc_ctrl_pkg::*;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic ce_i = 1'b1;
   reg_req_t req_i = '0;
   logic [RES_W-1:0] adc_result;
   logic [DATA_W-1:0] rdata_o;
   logic irq_o, conv_power_o, conv_busy_flag_o, conv_clk_tick_o, sample_o;
   logic [1:0] vref_sel_o;
   mux_sel_t mux_o;
   pin_ctl_t pins_o;
   int error_cnt = 0;
   int check_count = 0;
   int n;
   logic [7:0] d;
   logic [11:0] code;
   logic [2:0] srcs [8] = '{3'h0, 3'h5, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4, 3'h0};
   logic [3:0] chans [8] = '{4'h0, 4'h3, 4'h2, 4'h0, 4'h1, 4'h1, 4'h0, 4'h6};
   logic [1:0] fk [8] = '{2'h0, 2'h3, 2'h2, 2'h1, 2'h0, 2'h2, 2'h3, 2'h1};

   always #50 clk_i = ~clk_i;

   adc_control #(.CONV_CLKS(4)) i_adc_control (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
      .req_i(req_i), .adc_result_i(adc_result), .rdata_o(rdata_o), .irq_o(irq_o),
      .conv_power_o(conv_power_o), .conv_busy_flag_o(conv_busy_flag_o),
      .conv_clk_tick_o(conv_clk_tick_o), .sample_o(sample_o), .vref_sel_o(vref_sel_o),
      .mux_o(mux_o), .pins_o(pins_o));
   analog_core_model i_analog_core_model (.clk_i(clk_i), .busy_i(conv_busy_flag_o),
      .mux_i(mux_o), .result_o(adc_result));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk_data(input logic [11:0] got, input logic [11:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bus cycles start and end on a rising edge; a one-cycle gap avoids double assignment
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      req_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      req_i <= '0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      req_i <= '0;
      @(negedge clk_i);
      v = rdata_o;
      @(posedge clk_i);
   endtask
   task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
      rd(a, d);
      chk_data({4'h0, d}, {4'h0, exp});
   endtask
   task automatic wait_idle;
      for (n = 0; n < 3000; n++) begin
         @(negedge clk_i);
         if (conv_busy_flag_o === 1'b0) break;
      end
      if (n == 3000) begin
         error_cnt++;
         final_report();
      end
      @(posedge clk_i);
   endtask
   task automatic wait_tick(output int c);
      c = 0;
      do begin
         @(negedge clk_i);
         c++;
      end while (conv_clk_tick_o !== 1'b1 && c < 300);
      if (c >= 300) begin
         error_cnt++;
         final_report();
      end
   endtask
   function automatic logic [11:0] exp_code(input logic [2:0] s, input logic [3:0] ch);
      if (s == 3'h1) return 12'h5A3;
      if (s == 3'h2) return 12'hC3C;
      if (s == 3'h3) return 12'h19E;
      if (s != 3'h4 && ch < 4'h4) return 12'hA50 | {8'h00, ch};
      return 12'hFFF;
   endfunction
   function automatic mux_sel_t exp_mux(input logic [2:0] s, input logic [3:0] ch);
      mux_sel_t m;
      m = '{bandgap: s == 3'h1, amp0: s == 3'h2, amp1: s == 3'h3, ext: 4'h0};
      if ((s == 3'h0 || s >= 3'h5) && ch < 4'h4) m.ext = 4'h1 << ch;
      return m;
   endfunction
   // Launch through a start pulse, poll busy, then read both result bytes
   task automatic conv(input logic [2:0] s, input logic [3:0] ch, input logic f,
      input logic [2:0] k);
      code = exp_code(s, ch);
      wr(IDX_CTRL_B, {s, 2'h1, k});
      wr(IDX_CTRL_A, {3'b101, f, ch});
      wr(IDX_CTRL_A, {3'b001, f, ch});
      rd(IDX_CTRL_A, d);
      chk_bit(d[6], 1'b1);
      chk_data({5'h00, mux_o}, {5'h00, exp_mux(s, ch)});
      chk_data({10'h0, vref_sel_o}, 12'h001);
      wait_idle();
      rchk(IDX_RES_HI, f ? {4'h0, code[11:8]} : code[11:4]);
      rchk(IDX_RES_LO, f ? code[7:0] : {code[3:0], 4'h0});
      rd(IDX_CTRL_A, d);
      chk_bit(d[6], 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      for (int a = 0; a < 8; a++) rchk(a[2:0], 8'h00);
      wr(IDX_CTRL_A, 8'h5F);
      rchk(IDX_CTRL_A, 8'h1F);
      @(negedge clk_i);
      chk_bit(conv_power_o, 1'b0);
      @(posedge clk_i);
      wr(IDX_CTRL_A, 8'h20);
      rd(IDX_CTRL_A, d);
      chk_bit(d[6], 1'b0);
      chk_bit(conv_power_o, 1'b1);
      wr(IDX_IRQ_MASK, 8'h01);
      rchk(IDX_IRQ_MASK, 8'h01);
      for (int i = 0; i < 8; i++) begin
         conv(srcs[i], chans[i], fk[i][1], {2'h0, fk[i][0]});
         @(negedge clk_i);
         chk_bit(irq_o, 1'b1);
         @(posedge clk_i);
         rchk(IDX_IRQ_STS, 8'h01);
         @(negedge clk_i);
         chk_bit(irq_o, 1'b0);
         @(posedge clk_i);
      end
      // Masked completion keeps the line low until the mask opens
      wr(IDX_IRQ_MASK, 8'h00);
      conv(3'h1, 4'h0, 1'b0, 3'h0);
      @(negedge clk_i);
      chk_bit(irq_o, 1'b0);
      @(posedge clk_i);
      wr(IDX_IRQ_MASK, 8'h01);
      @(negedge clk_i);
      chk_bit(irq_o, 1'b1);
      @(posedge clk_i);
      rchk(IDX_IRQ_STS, 8'h01);
      // Disabled converter ignores a start pulse and holds results
      wr(IDX_CTRL_A, 8'h00);
      wr(IDX_CTRL_A, 8'h80);
      wr(IDX_CTRL_A, 8'h00);
      rd(IDX_CTRL_A, d);
      chk_bit(d[6], 1'b0);
      // Abort by disabling mid conversion, with the format flipped
      wr(IDX_CTRL_B, 8'h27);
      wr(IDX_CTRL_A, 8'hB0);
      wr(IDX_CTRL_A, 8'h30);
      @(negedge clk_i);
      chk_bit(sample_o, 1'b1);
      @(posedge clk_i);
      wr(IDX_CTRL_A, 8'h00);
      @(negedge clk_i);
      chk_bit(sample_o, 1'b0);
      @(posedge clk_i);
      rd(IDX_CTRL_A, d);
      chk_bit(d[6], 1'b0);
      rchk(IDX_RES_HI, 8'h5A);
      rchk(IDX_RES_LO, 8'h30);
      rchk(IDX_IRQ_STS, 8'h00);
      wr(IDX_CTRL_A, 8'h20);
      for (int k = 0; k < 8; k++) begin
         wr(IDX_CTRL_B, {5'h00, k[2:0]});
         wait_tick(n);
         wait_tick(n);
         wait_tick(n);
         chk_data(n[11:0], 12'h001 << k);
      end
      for (int s = 0; s < 8; s++) begin
         for (int ch = 0; ch < 16; ch++) begin
            wr(IDX_CTRL_B, {s[2:0], 5'h00});
            wr(IDX_CTRL_A, {4'h2, ch[3:0]});
            @(negedge clk_i);
            chk_data({5'h00, mux_o}, {5'h00, exp_mux(s[2:0], ch[3:0])});
            @(posedge clk_i);
         end
      end
      wr(IDX_PIN_SEL, 8'h09);
      @(negedge clk_i);
      chk_data(pins_o, {3{4'h9}});
      @(posedge clk_i);
      ce_i <= 1'b0;
      wr(IDX_PIN_SEL, 8'h06);
      ce_i <= 1'b1;
      rchk(IDX_PIN_SEL, 8'h09);
      final_report();
   end
endmodule
`default_nettype wire
